// ---- design/fsps_sequencer.sv ----
// Flash self-programming sequencer: control register, timed
// store/load windows, page buffer, erase/write/lock timing.
// Assumes CPU decode pulses spm/lpm for one cycle each and
// the flash macro follows the erase/write/lock levels.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fsps_regs.svh"
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `FSPS_PROG_MIN_US * `FSPS_CLK_MHZ,
  parameter logic [8:0] NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = `FSPS_NO_READ_WHILE_WRITE_AREA_PAGE,
  parameter logic [8:0] BOOT_FIRST_PAGE = `FSPS_BOOT_PAGE
)(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic spm_exec_i,
  input wire logic lpm_exec_i,
  input wire logic [16:0] ptr_i,
  input wire logic [7:0] r0_i,
  input wire logic [7:0] r1_i,
  input wire logic eeprom_write_active_i,
  input wire logic [7:0] fuse_low_i,
  input wire logic [7:0] fuse_high_i,
  input wire logic [1:0] fuse_ext_i,
  input wire logic [1:0] mem_lock_i,
  input wire logic [3:0] boot_lock_i,
  input wire logic [6:0] flash_buf_addr_i,
  output logic [15:0] flash_buf_data_o,
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic flash_lock_o,
  output logic [8:0] flash_page_o,
  output logic [3:0] flash_lock_data_o,
  output logic cpu_halt_o,
  output logic rww_read_block_o,
  output logic irq_o,
  output logic lpm_valid_o,
  output logic [7:0] lpm_data_o
);
  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [7:0] CTRL_RESET = `FSPS_CTRL_RST;

  fsps_state_t state_q;
  logic ctrl_en_q;
  logic [3:0] cmd_q;
  logic irq_en_q;
  logic rww_busy_q;
  logic [2:0] win_q;
  logic [2:0] lwin_q;
  logic [CW-1:0] cnt_q;
  logic buf_loaded_q;
  logic [23:0] nv_sync;
  logic [7:0] s_fuse_low;
  logic [7:0] s_fuse_high;
  logic [1:0] s_fuse_ext;
  logic [1:0] s_mem_lock;
  logic [3:0] s_boot_lock;
  logic [4:0] code;
  logic reg_hit;
  logic idle;
  logic ctrl_wr;
  logic cmd_arm;
  logic spm_ok;
  logic lpm_hit;
  logic go_fill;
  logic go_erase;
  logic go_write;
  logic go_lock;
  logic go_reen;
  logic prog_done;
  logic win_expire;
  logic buf_clr;

  // True when a store into this page is forbidden by the locks
  function automatic logic page_locked(input logic [8:0] page,
                                       input logic [3:0] locks);
    if (page < BOOT_FIRST_PAGE)
      page_locked = ~locks[`FSPS_APP_LOCK_BIT];
    else
      page_locked = ~locks[`FSPS_BOOT_LOCK_BIT];
  endfunction : page_locked

  // Fuse and lock values live in another domain
  fsps_sync #(
    .W(24)
  ) u_nv_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .async_i({fuse_low_i, fuse_high_i, fuse_ext_i, mem_lock_i, boot_lock_i}),
    .sync_o(nv_sync)
  );

  // Unpack the synchronised nonvolatile bits
  assign s_fuse_low = nv_sync[23:16];
  assign s_fuse_high = nv_sync[15:8];
  assign s_fuse_ext = nv_sync[7:6];
  assign s_mem_lock = nv_sync[5:4];
  assign s_boot_lock = nv_sync[3:0];

  // Register access and command decode
  assign reg_hit = (reg_addr_i == `FSPS_CTRL_OFS);
  assign idle = (state_q == FSPS_IDLE);
  assign code = {cmd_q, ctrl_en_q};
  assign ctrl_wr = reg_wr_i && reg_hit && !eeprom_write_active_i;
  assign cmd_arm = ctrl_wr && idle && reg_wdata_i[`FSPS_EN_BIT];

  // Store accepted only inside the four-cycle window
  assign spm_ok = spm_exec_i && (win_q != 3'h0) && ctrl_en_q && idle
                  && !eeprom_write_active_i;
  assign go_fill = spm_ok && (code == `FSPS_CMD_FILL);
  assign go_erase = spm_ok && (code == `FSPS_CMD_ERASE)
                    && !page_locked(ptr_i[16:8], s_boot_lock);
  assign go_write = spm_ok && (code == `FSPS_CMD_WRITE)
                    && !page_locked(ptr_i[16:8], s_boot_lock);
  assign go_lock = spm_ok && (code == `FSPS_CMD_LOCK);
  assign go_reen = spm_ok && (code == `FSPS_CMD_REEN);

  // Load within three cycles reads fuses or locks
  assign lpm_hit = lpm_exec_i && (lwin_q != 3'h0) && idle
                   && (code == `FSPS_CMD_LOCK)
                   && !eeprom_write_active_i;

  // Window lapses with no store: command dropped
  assign win_expire = (win_q == 3'h1) && !spm_ok;
  assign prog_done = !idle && (cnt_q == CNT_ONE);

  // Every path that empties the temporary buffer
  assign buf_clr = (prog_done && (state_q == FSPS_WRITE))
                   || (ctrl_wr && reg_wdata_i[`FSPS_REEN_BIT])
                   || go_reen
                   || (eeprom_write_active_i && buf_loaded_q);

  // Enable and command bits of the control register
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ctrl_en_q <= CTRL_RESET[`FSPS_EN_BIT];
      cmd_q <= 4'h0;
    end
    else if (clk_en_i)
    begin
      if (prog_done)
      begin
        ctrl_en_q <= 1'b0;
        cmd_q <= 4'h0;
      end
      else if (cmd_arm)
      begin
        ctrl_en_q <= 1'b1;
        cmd_q <= reg_wdata_i[4:1];
      end
      else if (go_erase || go_write || go_lock)
      begin
        ctrl_en_q <= 1'b1;
      end
      else if (spm_ok || lpm_hit || (idle && win_expire))
      begin
        // Refused, single-cycle or lapsed commands end here
        ctrl_en_q <= 1'b0;
        cmd_q <= 4'h0;
      end
    end
  end

  // Store and load windows, armed by the register write
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      win_q <= 3'h0;
      lwin_q <= 3'h0;
    end
    else if (clk_en_i)
    begin
      if (cmd_arm)
      begin
        win_q <= `FSPS_STORE_WIN;
        lwin_q <= `FSPS_LOAD_WIN;
      end
      else
      begin
        if (spm_ok || lpm_hit || win_q == 3'h0)
          win_q <= 3'h0;
        else
          win_q <= win_q - 3'h1;
        if (spm_ok || lpm_hit || lwin_q == 3'h0)
          lwin_q <= 3'h0;
        else
          lwin_q <= lwin_q - 3'h1;
      end
    end
  end

  // Interrupt enable is writable even during an operation
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      irq_en_q <= CTRL_RESET[`FSPS_IRQEN_BIT];
    else if (clk_en_i && reg_wr_i && reg_hit)
      irq_en_q <= reg_wdata_i[`FSPS_IRQEN_BIT];
  end

  // Level interrupt while the enable bit reads clear
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else if (clk_en_i)
      irq_o <= irq_en_q && !ctrl_en_q;
  end

  // Operation sequencer and programming timer
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= FSPS_IDLE;
      cnt_q <= '0;
      flash_page_o <= 9'h000;
      flash_lock_data_o <= 4'hf;
    end
    else if (clk_en_i)
    begin
      case (state_q)
        FSPS_IDLE:
        begin
          if (go_erase || go_write)
          begin
            state_q <= go_erase ? FSPS_ERASE : FSPS_WRITE;
            cnt_q <= PROG_LOAD;
            flash_page_o <= ptr_i[16:8];
          end
          else if (go_lock)
          begin
            state_q <= FSPS_LOCK;
            cnt_q <= PROG_LOAD;
            flash_lock_data_o <= r0_i[5:2];
          end
        end
        FSPS_ERASE, FSPS_WRITE, FSPS_LOCK:
        begin
          // Fixed count stands in for the RC oscillator time
          if (prog_done)
            state_q <= FSPS_IDLE;
          else
            cnt_q <= cnt_q - CNT_ONE;
        end
        default:
        begin
          state_q <= FSPS_IDLE;
        end
      endcase
    end
  end

  // Flash macro strobes follow the running operation
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_lock_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (prog_done)
      begin
        flash_erase_o <= 1'b0;
        flash_write_o <= 1'b0;
        flash_lock_o <= 1'b0;
      end
      else if (idle)
      begin
        flash_erase_o <= go_erase;
        flash_write_o <= go_write;
        flash_lock_o <= go_lock;
      end
    end
  end

  // Halt only when the target page holds running code
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      cpu_halt_o <= 1'b0;
    else if (clk_en_i)
    begin
      if (prog_done)
        cpu_halt_o <= 1'b0;
      else if ((go_erase || go_write) && ptr_i[16:8] >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE)
        cpu_halt_o <= 1'b1;
      // Lock programming leaves fetch running
      else if (go_lock)
        cpu_halt_o <= 1'b0;
    end
  end

  // Read-while-write area blocked for the whole erase or write
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rww_read_block_o <= 1'b0;
    else if (clk_en_i)
    begin
      if (prog_done)
        rww_read_block_o <= 1'b0;
      else if (go_erase || go_write)
        rww_read_block_o <= 1'b1;
    end
  end

  // Busy flag outlives the operation until re-enabled
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rww_busy_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (go_erase || go_write)
        rww_busy_q <= 1'b1;
      else if (go_reen)
        rww_busy_q <= 1'b0;
    end
  end

  // Tracks whether loaded words could be discarded
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      buf_loaded_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (go_fill)
        buf_loaded_q <= 1'b1;
      else if (buf_clr)
        buf_loaded_q <= 1'b0;
    end
  end

  // Temporary page buffer; slot from the word field
  fsps_page_buf #(
    .WORDS(128),
    .AW(7)
  ) u_page_buf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .clr_i(buf_clr),
    .wr_i(go_fill),
    .waddr_i(ptr_i[7:1]),
    .wdata_i({r1_i, r0_i}),
    .raddr_i(flash_buf_addr_i),
    .rdata_o(flash_buf_data_o)
  );

  // Fuse and lock readback; bits stay in stored polarity
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      lpm_valid_o <= 1'b0;
      lpm_data_o <= `FSPS_ALL_ONES;
    end
    else if (clk_en_i)
    begin
      lpm_valid_o <= lpm_hit;
      if (lpm_hit)
      begin
        case (ptr_i[15:0])
          `FSPS_PTR_FLOW:
            lpm_data_o <= s_fuse_low;
          `FSPS_PTR_LOCK:
            lpm_data_o <= {2'b11, s_boot_lock, s_mem_lock};
          `FSPS_PTR_FEXT:
            lpm_data_o <= {6'h3f, s_fuse_ext};
          `FSPS_PTR_FHIGH:
            lpm_data_o <= s_fuse_high;
          default:
            lpm_data_o <= `FSPS_ALL_ONES;
        endcase
      end
    end
  end

  // Register read data stand only in the following cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (clk_en_i)
    begin
      if (reg_rd_i && reg_hit)
        reg_rdata_o <= {irq_en_q, rww_busy_q, 1'b0, cmd_q, ctrl_en_q};
      else
        reg_rdata_o <= 8'h00;
    end
  end
endmodule : fsps_sequencer
`default_nettype wire

// ---- include/fsps_regs.svh ----
// Constants of the flash self-programming sequencer.
// Assumes a 200 MHz core clock; included once per compile unit.
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH
`define FSPS_CTRL_OFS 4'h0
`define FSPS_CTRL_RST 8'h00
`define FSPS_EN_BIT 0
`define FSPS_REEN_BIT 4
`define FSPS_IRQEN_BIT 7
`define FSPS_CMD_FILL 5'h01
`define FSPS_CMD_ERASE 5'h03
`define FSPS_CMD_WRITE 5'h05
`define FSPS_CMD_LOCK 5'h09
`define FSPS_CMD_REEN 5'h11
`define FSPS_STORE_WIN 3'h4
`define FSPS_LOAD_WIN 3'h3
`define FSPS_CLK_MHZ 200
`define FSPS_PROG_MIN_US 3700
`define FSPS_PROG_MAX_US 4500
`define FSPS_PTR_FLOW 16'h0000
`define FSPS_PTR_LOCK 16'h0001
`define FSPS_PTR_FEXT 16'h0002
`define FSPS_PTR_FHIGH 16'h0003
`define FSPS_NO_READ_WHILE_WRITE_AREA_PAGE 9'h1e0
`define FSPS_BOOT_PAGE 9'h1e0
`define FSPS_ERASED_WORD 16'hffff
`define FSPS_ALL_ONES 8'hff
`define FSPS_APP_LOCK_BIT 0
`define FSPS_BOOT_LOCK_BIT 2
`endif

// ---- include/fsps_pkg.sv ----
// Types shared by the sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package fsps_pkg;
  // Running operation of the flash array
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ERASE, FSPS_WRITE, FSPS_LOCK} fsps_state_t;
endpackage : fsps_pkg

// ---- design/fsps_sync.sv ----
// Two-stage synchroniser for a bus of quasi-static levels.
// Assumes each bit changes rarely; no word coherence promised.
`timescale 1ns/1ps
`default_nettype none
module fsps_sync #(
  parameter int W = 8
)(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else if (clk_en_i)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : fsps_sync
`default_nettype wire

// ---- design/fsps_page_buf.sv ----
// Temporary page buffer with one-cycle whole-buffer clear.
// Assumes one writer and one reader port on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "fsps_regs.svh"
module fsps_page_buf #(
  parameter int WORDS = 128,
  parameter int AW = 7
)(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem_q [WORDS];
  logic [WORDS-1:0] valid_q;

  // Valid bits let a clear finish in one cycle; a store in the
  // clearing cycle survives, so the set wins
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      valid_q <= '0;
    else if (clk_en_i)
    begin
      if (clr_i)
        valid_q <= '0;
      if (wr_i)
        valid_q[waddr_i] <= 1'b1;
    end
  end

  // Storage has no reset; valid bits mask it
  always_ff @(posedge sys_clk_i)
  begin
    if (clk_en_i && wr_i)
      mem_q[waddr_i] <= wdata_i;
  end

  // Empty slots read as erased flash
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      rdata_o <= `FSPS_ERASED_WORD;
    else if (clk_en_i)
      rdata_o <= valid_q[raddr_i] ? mem_q[raddr_i] : `FSPS_ERASED_WORD;
  end
endmodule : fsps_page_buf
`default_nettype wire

// ---- verif/fsps_sequencer_asserts.sv ----
// Checker for the flash self-programming sequencer top ports.
// Assumes clk_en_i held high; bound to the design at the file foot.
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer_asserts #(
  parameter int unsigned PROG_CYCLES = 20,
  parameter logic [8:0] NO_READ_WHILE_WRITE_AREA_FIRST_PAGE = 9'h1e0
)(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic spm_exec_i,
  input wire logic lpm_exec_i,
  input wire logic eeprom_write_active_i,
  input wire logic flash_erase_o,
  input wire logic flash_write_o,
  input wire logic flash_lock_o,
  input wire logic [8:0] flash_page_o,
  input wire logic cpu_halt_o,
  input wire logic rww_read_block_o,
  input wire logic irq_o,
  input wire logic lpm_valid_o
);
  logic pg_run;
  logic any_run;
  logic [31:0] run_cnt_q;
  assign pg_run = flash_erase_o | flash_write_o;
  assign any_run = pg_run | flash_lock_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Operation length; far too long for a repetition operator
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i || !any_run)
      run_cnt_q <= '0;
    else
      run_cnt_q <= run_cnt_q + 32'h1;
  end
  // Store taken one edge earlier, clear of an EEPROM write
  sequence s_store_taken;
    $past(spm_exec_i) && !$past(eeprom_write_active_i);
  endsequence
  // Control write two to five edges before the start
  sequence s_cmd_window;
    $past(reg_wr_i, 2) || $past(reg_wr_i, 3) || $past(reg_wr_i, 4) || $past(reg_wr_i, 5);
  endsequence
  chk_run_start: assert property ($rose(any_run) |-> s_store_taken)
    else $error("operation started without an accepted store");
  chk_store_window: assert property ($rose(any_run) |-> s_cmd_window)
    else $error("operation started outside the store window");
  chk_run_length: assert property ($fell(any_run) |-> run_cnt_q == PROG_CYCLES)
    else $error("operation length differs from the programming time");
  chk_end_together: assert property ($fell(pg_run) |-> !cpu_halt_o && !rww_read_block_o)
    else $error("halt or read block outlived the operation");
  chk_halt_page: assert property (cpu_halt_o |-> pg_run && flash_page_o >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE)
    else $error("halt without an operation on the protected pages");
  chk_halt_no_read_while_write_area: assert property ($rose(pg_run) && flash_page_o >= NO_READ_WHILE_WRITE_AREA_FIRST_PAGE |-> cpu_halt_o)
    else $error("operation on protected pages did not halt");
  chk_block_run: assert property (pg_run |-> rww_read_block_o)
    else $error("reads not blocked during erase or write");
  chk_lock_free: assert property (flash_lock_o |-> !cpu_halt_o && !rww_read_block_o)
    else $error("lock programming halted or blocked reads");
  chk_irq_quiet: assert property (any_run && $past(any_run) |-> !irq_o)
    else $error("interrupt raised while enable bit set");
  chk_load_window: assert property (lpm_valid_o |-> $past(lpm_exec_i)
      && ($past(reg_wr_i, 2) || $past(reg_wr_i, 3) || $past(reg_wr_i, 4)))
    else $error("fuse answer outside the load window");
endmodule : fsps_sequencer_asserts
bind fsps_sequencer fsps_sequencer_asserts #(.PROG_CYCLES(PROG_CYCLES),
  .NO_READ_WHILE_WRITE_AREA_FIRST_PAGE(NO_READ_WHILE_WRITE_AREA_FIRST_PAGE)) u_fsps_sequencer_asserts (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .reg_wr_i(reg_wr_i), .spm_exec_i(spm_exec_i), .lpm_exec_i(lpm_exec_i),
  .eeprom_write_active_i(eeprom_write_active_i), .flash_erase_o(flash_erase_o),
  .flash_write_o(flash_write_o), .flash_lock_o(flash_lock_o), .flash_page_o(flash_page_o),
  .cpu_halt_o(cpu_halt_o), .rww_read_block_o(rww_read_block_o), .irq_o(irq_o),
  .lpm_valid_o(lpm_valid_o));
`default_nettype wire

// ---- verif/fsps_cpu_model.sv ----
// CPU core stand-in issuing store and load instructions.
// Assumes the bench calls issue right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fsps_cpu_model (
  input wire logic sys_clk_i,
  output logic spm_exec_o,
  output logic lpm_exec_o,
  output logic [16:0] ptr_o,
  output logic [7:0] r0_o,
  output logic [7:0] r1_o
);
  initial
  begin
    spm_exec_o = 1'b0;
    lpm_exec_o = 1'b0;
    ptr_o = 17'h1ffff;
    r0_o = 8'hff;
    r1_o = 8'hff;
  end
  // One instruction gap cycles later; operands inverted once unused
  task automatic issue(input bit is_load, input int gap, input logic [16:0] p,
      input logic [7:0] lo, input logic [7:0] hi);
    repeat (gap) @(posedge sys_clk_i);
    ptr_o <= p;
    r0_o <= lo;
    r1_o <= hi;
    lpm_exec_o <= is_load;
    spm_exec_o <= !is_load;
    @(posedge sys_clk_i);
    spm_exec_o <= 1'b0;
    lpm_exec_o <= 1'b0;
    ptr_o <= ~p;
    r0_o <= ~lo;
    r1_o <= ~hi;
  endtask : issue
endmodule : fsps_cpu_model
`default_nettype wire

// ---- verif/fsps_sequencer_tb_top.sv ----
// Self-checking bench for the flash self-programming sequencer.
// Assumes design, checker and CPU model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer_tb_top;
  localparam int PC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic eep = 1'b0;
  logic [7:0] flo, fhi, rdata, ldata, r0, r1, v;
  logic [1:0] fex, mlk;
  logic [3:0] blk = 4'hf;
  logic [3:0] ldat;
  logic [6:0] bufa = 7'h00;
  logic [15:0] bdata;
  logic [16:0] ptr;
  logic [8:0] page;
  logic spm, load, ers, wrt, lck, halt, blkr, irq, lval, anyop;
  int bad_count = 0;
  int checks = 0;
  int oplen = 0;
  int mbusy = 0;
  int mbuf[128];
  always #2.5 clk = ~clk;
  always_comb anyop = ers | wrt | lck;
  // Operation length, zeroed by each scenario before it starts
  always @(posedge clk)
    if (anyop)
      oplen <= oplen + 1;
  fsps_sequencer #(.PROG_CYCLES(PC)) u_fsps_sequencer (.sys_clk_i(clk), .reset_i(rst),
    .clk_en_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .spm_exec_i(spm), .lpm_exec_i(load), .ptr_i(ptr), .r0_i(r0),
    .r1_i(r1), .eeprom_write_active_i(eep), .fuse_low_i(flo), .fuse_high_i(fhi),
    .fuse_ext_i(fex), .mem_lock_i(mlk), .boot_lock_i(blk), .flash_buf_addr_i(bufa),
    .flash_buf_data_o(bdata), .flash_erase_o(ers), .flash_write_o(wrt), .flash_lock_o(lck),
    .flash_page_o(page), .flash_lock_data_o(ldat), .cpu_halt_o(halt),
    .rww_read_block_o(blkr), .irq_o(irq), .lpm_valid_o(lval), .lpm_data_o(ldata));
  fsps_cpu_model u_fsps_cpu_model (.sys_clk_i(clk), .spm_exec_o(spm), .lpm_exec_o(load),
    .ptr_o(ptr), .r0_o(r0), .r1_o(r1));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic wreg(input logic [7:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= 4'h0;
    wd <= x;
    @(posedge clk);
    wr <= 1'b0;
    wd <= ~x;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 v = rdata;
  endtask : rreg
  task automatic clr();
    for (int k = 0; k < 128; k++)
      mbuf[k] = -1;
  endtask : clr
  task automatic bufchk();
    for (int k = 0; k < 128; k++)
    begin
      @(posedge clk);
      bufa <= k[6:0];
      @(posedge clk);
      #1 chk("buffer word", bdata, mbuf[k] < 0 ? 32'hffff : mbuf[k]);
    end
  endtask : bufchk
  // Distinct slots only: a slot is stored once between clears
  task automatic fill(input int n);
    int s;
    logic [15:0] w;
    for (int i = 0; i < n; i++)
    begin
      s = i * 21 + $urandom % 3;
      w = $urandom;
      wreg(8'h01);
      u_fsps_cpu_model.issue(1'b0, i % 4, {9'h000, s[6:0], 1'b0}, w[7:0], w[15:8]);
      mbuf[s] = w;
    end
  endtask : fill
  task automatic reen();
    wreg(8'h91);
    u_fsps_cpu_model.issue(1'b0, 0, 17'h0, 8'hff, 8'hff);
    mbusy = 0;
    clr();
  endtask : reen
  // One command with interrupt enabled; go says whether it must start
  task automatic run(input logic [7:0] cmd, input logic [8:0] pg, input int gap, input bit go);
    logic [7:0] lo;
    bit seen;
    bit lk;
    lk = cmd == 8'h09;
    lo = $urandom | 8'hc3;
    seen = 0;
    oplen = 0;
    wreg(cmd | 8'h80);
    u_fsps_cpu_model.issue(1'b0, gap, lk ? 17'h1 : {pg, 8'h00}, lo, 8'hff);
    repeat (3)
    begin
      #1 seen |= anyop;
      @(posedge clk);
    end
    #1 chk("op started", seen, go);
    if (seen)
    begin
      mbusy = lk ? mbusy : 1;
      chk("halt", halt, !lk && pg >= 9'h1e0);
      chk("read block", blkr, !lk);
      chk("target", lk ? ldat : page, lk ? lo[5:2] : pg);
      rreg(4'h0);
      chk("busy flag", v[6], mbusy);
      chk("enable bit", v[0], 1);
      for (int n = 0; n < 40 && anyop; n++)
        @(posedge clk) #1;
      if (anyop)
      begin
        bad_count++;
        end_of_test();
      end
      chk("op length", oplen, PC);
      if (cmd == 8'h05)
        clr();
    end
    rreg(4'h0);
    chk("enable bit", v[0], 0);
    chk("busy flag", v[6], mbusy);
    chk("irq", irq, 1);
  endtask : run
  function automatic logic [7:0] fuse_exp(input int p);
    case (p)
      0: return flo;
      1: return {2'b11, blk, mlk};
      2: return {6'h3f, fex};
      default: return fhi;
    endcase
  endfunction : fuse_exp
  // Main sequence: reset, buffer, operations, fuse reads
  initial
  begin
    void'($urandom(32'h9de182d1));
    flo = $urandom;
    fhi = $urandom;
    fex = $urandom;
    mlk = $urandom;
    clr();
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rreg(4'h0);
    chk("control after reset", v, 0);
    rreg(4'h7);
    chk("unmapped read", v, 0);
    chk("load data after reset", ldata, 8'hff);
    bufchk();
    fill(6);
    bufchk();
    @(posedge clk);
    eep <= 1'b1;
    @(posedge clk);
    eep <= 1'b0;
    clr();
    bufchk();
    fill(3);
    reen();
    bufchk();
    run(8'h03, 9'h005, 0, 1);
    fill(2);
    run(8'h05, 9'h1f0, 3, 1);
    bufchk();
    reen();
    run(8'h09, 9'h000, 1, 1);
    run(8'h03, 9'h005, 4, 0);
    @(posedge clk);
    eep <= 1'b1;
    run(8'h05, 9'h1f0, 0, 0);
    @(posedge clk);
    eep <= 1'b0;
    blk <= 4'he;
    run(8'h03, 9'h005, 0, 0);
    @(posedge clk);
    blk <= 4'($urandom) | 4'h5;
    repeat (3) @(posedge clk);
    for (int p = 0; p < 4; p++)
    begin
      wreg(8'h09);
      u_fsps_cpu_model.issue(1'b1, p % 3, 17'(p), 8'hff, 8'hff);
      #1 chk("load valid", lval, 1);
      chk("load data", ldata, fuse_exp(p));
    end
    wreg(8'h09);
    u_fsps_cpu_model.issue(1'b1, 3, 17'h1, 8'hff, 8'hff);
    #1 chk("late load valid", lval, 0);
    rreg(4'h0);
    chk("lock-set cleared", v[4:0], 0);
    @(posedge clk);
    eep <= 1'b1;
    wreg(8'h09);
    u_fsps_cpu_model.issue(1'b1, 0, 17'h1, 8'hff, 8'hff);
    #1 chk("blocked load valid", lval, 0);
    @(posedge clk);
    eep <= 1'b0;
    // Armed cleanly, then the EEPROM write starts beside the load
    wreg(8'h09);
    eep <= 1'b1;
    u_fsps_cpu_model.issue(1'b1, 0, 17'h1, 8'hff, 8'hff);
    #1 chk("load during eeprom", lval, 0);
    @(posedge clk);
    eep <= 1'b0;
    chk("irq masked", irq, 0);
    end_of_test();
  end
endmodule : fsps_sequencer_tb_top
`default_nettype wire
